// File: usb_event_flag_register.sv
// Functional notes
// [RULE_01] The start-of-frame flag is set when the engine reports a received start-of-frame token and stays clear otherwise.
// [RULE_02] The stall flag is set when the engine reports a sent STALL handshake and stays clear otherwise.
// [RULE_03] The idle flag is set once the bus has been idle without a break for 3 ms or longer.
// [RULE_04] Bit 7 of the event flag register always reads as zero.
// [RULE_05] Every implemented event flag is zero after reset.
// [RULE_06] Software normally unmasks the activity interrupt only after an idle event, so resume activity wakes the device.
// [RULE_07] The summary error flag is set only by error conditions whose enable bits are set.
// [RULE_08] The summary error flag is read-only and follows the enabled individual errors.
// [RULE_09] A finished transaction sets the transaction flag, and clearing that flag advances the status FIFO.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
module usb_event_flag_register
	import usb_event_pkg::*;
#(
	parameter int IDLE_CYCLES = IDLE_CYC_DEF
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// axi4-lite write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [DATA_W-1:0]      rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// engine side
	input  wire usb_events_s       events,
	input  wire logic              bus_idle,
	input  wire logic [FLAG_W-1:0] err_flags,
	output logic                   fifo_advance,
	output logic                   address_clear,
	// interrupt
	output logic                   irq
);

	function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
		if (addr[ADDR_W-1:2] == OFS_FLAGS[ADDR_W-1:2])
			return SEL_FLAGS;
		else if (addr[ADDR_W-1:2] == OFS_MASK[ADDR_W-1:2])
			return SEL_MASK;
		else if (addr[ADDR_W-1:2] == OFS_ERR_EN[ADDR_W-1:2])
			return SEL_ERR_EN;
		else
			return SEL_NONE;
	endfunction

	logic [ADDR_W-1:0]     awaddr_r;
	logic                  aw_held_r;
	logic [DATA_W-1:0]     wdata_r;
	logic [3:0]            wstrb_r;
	logic                  w_held_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic                  rvalid_r;
	logic [1:0]            rresp_r;
	logic [DATA_W-1:0]     rdata_r;
	logic                  rd_flags_r;
	logic [FLAG_W-1:0]     flags_r;
	logic [FLAG_W-1:0]     flags_nxt;
	logic [FLAG_W-1:0]     mask_r;
	logic [FLAG_W-1:0]     err_en_r;
	logic                  err_sum_r;
	logic [IDLE_CNT_W-1:0] idle_cnt_r;
	logic                  idle_hit;
	logic                  fifo_adv_r;
	logic                  addr_clr_r;
	logic                  do_write;
	logic                  wr_low;
	reg_sel_e              wr_sel;
	logic [FLAG_W-1:0]     set_vec;
	logic [FLAG_W-1:0]     clr_vec;
	logic                  trn_clear;

	localparam logic [IDLE_CNT_W-1:0] IDLE_MAX = IDLE_CNT_W'(IDLE_CYCLES);

	assign awready      = !aw_held_r && !bvalid_r;
	assign wready       = !w_held_r && !bvalid_r;
	assign arready      = !rvalid_r;
	assign bvalid       = bvalid_r;
	assign bresp        = bresp_r;
	assign rvalid       = rvalid_r;
	assign rresp        = rresp_r;
	assign rdata        = rdata_r;
	assign fifo_advance = fifo_adv_r;
	assign address_clear = addr_clr_r;

	assign do_write  = aw_held_r && w_held_r && !bvalid_r;
	assign wr_sel    = decode(awaddr_r);
	assign wr_low    = do_write && wstrb_r[0];
	assign trn_clear = wr_low && (wr_sel == SEL_FLAGS) && wdata_r[BIT_TRN] && flags_r[BIT_TRN];

	// write address and data are taken independently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (awvalid && awready) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= awaddr;
		end else if (do_write) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end else if (wvalid && wready) begin
			w_held_r <= 1'b1;
			wdata_r  <= wdata;
			wstrb_r  <= wstrb;
		end else if (do_write) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r   <= 1'b0;
			rresp_r    <= RESP_OKAY;
			rdata_r    <= '0;
			rd_flags_r <= 1'b0;
		end else if (arvalid && arready) begin
			rvalid_r   <= 1'b1;
			rresp_r    <= RESP_OKAY;
			rd_flags_r <= 1'b0;
			rdata_r    <= '0;
			case (decode(araddr))
				SEL_FLAGS: begin
					rdata_r[FLAG_W-1:0] <= flags_r & MASK_IMPL; // RULE_04
					rd_flags_r          <= 1'b1;
				end
				SEL_MASK:   rdata_r[FLAG_W-1:0] <= mask_r;
				SEL_ERR_EN: rdata_r[FLAG_W-1:0] <= err_en_r;
				default:    rresp_r <= RESP_SLVERR;
			endcase
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r   <= MASK_RST;
			err_en_r <= ERR_EN_RST;
		end else if (wr_low) begin
			if (wr_sel == SEL_MASK)
				mask_r <= wdata_r[FLAG_W-1:0] & MASK_IMPL;
			if (wr_sel == SEL_ERR_EN)
				err_en_r <= wdata_r[FLAG_W-1:0];
		end
	end

	// continuous idle counter, saturates so one idle period gives one event
	always_ff @(posedge aclk) begin
		if (!aresetn)
			idle_cnt_r <= '0;
		else if (!bus_idle)
			idle_cnt_r <= '0;
		else if (idle_cnt_r != IDLE_MAX)
			idle_cnt_r <= idle_cnt_r + 1'b1;
	end

	assign idle_hit = bus_idle && (idle_cnt_r == IDLE_MAX - 1'b1); // RULE_03

	// summary error follows enabled errors only; writes never touch it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			err_sum_r <= 1'b0;
		else
			err_sum_r <= |(err_flags & err_en_r); // RULE_07 RULE_08
	end

	always_comb begin
		set_vec            = '0;
		set_vec[BIT_SOF]   = events.frame_start; // RULE_01
		set_vec[BIT_STALL] = events.stall_sent; // RULE_02
		set_vec[BIT_IDLE]  = idle_hit; // RULE_03
		set_vec[BIT_TRN]   = events.trn_done; // RULE_09
		set_vec[BIT_ACTV]  = events.activity;
		set_vec[BIT_URST]  = events.bus_reset;
		clr_vec            = '0;
		if (wr_low && (wr_sel == SEL_FLAGS))
			clr_vec = wdata_r[FLAG_W-1:0] & FLAGS_W1C;
		// a set in the same cycle as a clear wins
		flags_nxt          = (flags_r & ~clr_vec) | set_vec;
		flags_nxt[BIT_UERR]   = err_sum_r; // RULE_08
		flags_nxt[BIT_UNUSED] = 1'b0; // RULE_04
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			flags_r <= FLAGS_RST; // RULE_05
		else
			flags_r <= flags_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifo_adv_r <= 1'b0;
			addr_clr_r <= 1'b0;
			irq        <= 1'b0;
		end else begin
			fifo_adv_r <= trn_clear; // RULE_09
			addr_clr_r <= events.bus_reset;
			irq        <= |(flags_nxt & mask_r);
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_flags_trn;
		trn_clear;
	endsequence

	sequence s_advance_once;
		fifo_advance ##1 !fifo_advance;
	endsequence

	sequence s_both_taken;
		awvalid && awready && wvalid && wready;
	endsequence

	sequence s_ar_taken;
		arvalid && arready;
	endsequence

	// no enabled error condition in this cycle
	sequence s_err_quiet;
		!(|(err_flags & err_en_r));
	endsequence

	a_sof_sets: assert property (events.frame_start |=> flags_r[BIT_SOF]) // RULE_01
		else $error("frame start flag not set");
	a_stall_sets: assert property (events.stall_sent |=> flags_r[BIT_STALL]) // RULE_02
		else $error("stall flag not set");
	a_stall_quiet: assert property (!flags_r[BIT_STALL] && !events.stall_sent |=> !flags_r[BIT_STALL]) // RULE_02
		else $error("stall flag set with no stall");
	a_idle_sets: assert property (idle_hit |=> flags_r[BIT_IDLE] && idle_cnt_r == IDLE_MAX) // RULE_03
		else $error("idle flag not set after idle time");
	a_idle_early: assert property (!flags_r[BIT_IDLE] && idle_cnt_r < IDLE_MAX - 1'b1 |=> !flags_r[BIT_IDLE]) // RULE_03
		else $error("idle flag set too early");
	a_msb_zero: assert property (rvalid && rd_flags_r |-> !rdata[BIT_UNUSED]) // RULE_04
		else $error("flag register bit 7 read as one");
	a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> flags_r == FLAGS_RST) // RULE_05
		else $error("flags not clear after reset");
	a_err_follows: assert property (##1 flags_r[BIT_UERR] == $past(|(err_flags & err_en_r), 2)) // RULE_07 RULE_08
		else $error("summary error does not follow enabled errors");
	a_trn_advance: assert property (s_wr_flags_trn |=> s_advance_once) // RULE_09
		else $error("status fifo not advanced on clear");
	a_no_advance: assert property (!trn_clear |=> !fifo_advance) // RULE_09
		else $error("status fifo advanced without clear");
	a_trn_sets: assert property (events.trn_done |=> flags_r[BIT_TRN]) // RULE_09
		else $error("transaction flag not set");
	a_write_resp: assert property (s_both_taken |=> ##1 bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_ar_taken |=> rvalid)
		else $error("read answer late");
	a_sof_quiet: assert property (!flags_r[BIT_SOF] && !events.frame_start |=> !flags_r[BIT_SOF]) // RULE_01
		else $error("frame start flag set with no token");
	a_trn_quiet: assert property (!flags_r[BIT_TRN] && !events.trn_done |=> !flags_r[BIT_TRN]) // RULE_09
		else $error("transaction flag set with no transaction");
	a_act_sets: assert property (events.activity |=> flags_r[BIT_ACTV])
		else $error("activity flag not set");
	a_urst_sets: assert property (events.bus_reset |=> flags_r[BIT_URST] && address_clear)
		else $error("bus reset flag or address clear missing");
	a_idle_count: assert property ($rose(flags_r[BIT_IDLE]) |-> $past(bus_idle) && $past(idle_cnt_r) == IDLE_MAX - 1'b1) // RULE_03
		else $error("idle flag set without full idle period");
	a_flag_msb: assert property (!flags_r[BIT_UNUSED]) // RULE_04
		else $error("unimplemented flag bit set");
	a_rdata_upper: assert property (rvalid |-> rdata[DATA_W-1:FLAG_W] == '0)
		else $error("read data upper bits not zero");
	a_err_masked: assert property (s_err_quiet |=> ##1 !flags_r[BIT_UERR]) // RULE_07
		else $error("summary error set by masked error");
	a_err_readonly: assert property (wr_low && wr_sel == SEL_FLAGS && err_sum_r |=> flags_r[BIT_UERR]) // RULE_08
		else $error("summary error cleared by write");
	a_reset_outputs: assert property (disable iff (1'b0) !aresetn |=> !irq && !bvalid && !rvalid && !fifo_advance)
		else $error("outputs not idle after reset");
	a_irq_level: assert property (irq == $past(|(flags_nxt & mask_r)))
		else $error("interrupt does not follow flags");

endmodule

// File: usb_event_pkg.sv
package usb_event_pkg;

	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          FLAG_W       = 8;

	// register byte offsets
	localparam logic [7:0]  OFS_FLAGS    = 8'h00;
	localparam logic [7:0]  OFS_MASK     = 8'h04;
	localparam logic [7:0]  OFS_ERR_EN   = 8'h08;

	// event flag bit positions
	localparam int          BIT_UNUSED   = 7;
	localparam int          BIT_SOF      = 6;
	localparam int          BIT_STALL    = 5;
	localparam int          BIT_IDLE     = 4;
	localparam int          BIT_TRN      = 3;
	localparam int          BIT_ACTV     = 2;
	localparam int          BIT_UERR     = 1;
	localparam int          BIT_URST     = 0;

	// bits that software clears by writing one; summary error and bit 7 excluded
	localparam logic [7:0]  FLAGS_W1C    = 8'h7D;
	localparam logic [7:0]  MASK_IMPL    = 8'h7F;

	localparam logic [7:0]  FLAGS_RST    = 8'h00;
	localparam logic [7:0]  MASK_RST     = 8'h00;
	localparam logic [7:0]  ERR_EN_RST   = 8'h00;

	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	// idle detect time
	localparam int          CLK_KHZ      = 40000;
	localparam int          IDLE_TIME_MS = 3;
	localparam int          IDLE_CYC_DEF = IDLE_TIME_MS * CLK_KHZ;
	localparam int          IDLE_CNT_W   = 17;

	typedef enum logic [3:0] {
		SEL_NONE   = 4'b0001,
		SEL_FLAGS  = 4'b0010,
		SEL_MASK   = 4'b0100,
		SEL_ERR_EN = 4'b1000
	} reg_sel_e;

	// one-cycle event pulses from the serial interface engine
	typedef struct packed {
		logic frame_start;
		logic stall_sent;
		logic trn_done;
		logic activity;
		logic bus_reset;
	} usb_events_s;

endpackage

// File: usb_engine_model.sv
module usb_engine_model
	import usb_event_pkg::*;
(
	// clock
	input  wire logic         aclk,
	// engine side of the flag block
	output usb_events_s       events,
	output logic              bus_idle,
	output logic [FLAG_W-1:0] err_flags
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		events = '0;
		bus_idle = 1'b0;
		err_flags = '0;
	end

	// one-cycle pulse, sampled at the next edge
	task automatic pulse(input logic [4:0] v);
		events <= v;
		@(posedge aclk);
		events <= '0;
	endtask

	// idle for n sampled cycles, then one busy cycle breaks the period
	task automatic idle_for(input int n);
		bus_idle <= 1'b1;
		repeat (n) @(posedge aclk);
		bus_idle <= 1'b0;
		@(posedge aclk);
	endtask

	// error level, held long enough for the summary to follow
	task automatic set_err(input logic [7:0] v);
		err_flags <= v;
		repeat (3) @(posedge aclk);
	endtask
endmodule

// File: usb_event_flag_register_bench.sv
module usb_event_flag_register_bench
	import usb_event_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, s); end end

	localparam int IDLE_N = 20;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [7:0]        awaddr = '0, araddr = '0;
	logic [31:0]       wdata = '0, rdv, rv;
	logic [3:0]        wstrb = '0;
	logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic              awready, wready, bvalid, arready, rvalid, irq, fifo_advance, address_clear;
	logic [1:0]        bresp, rresp, resp;
	logic [31:0]       rdata;
	usb_events_s       events;
	logic              bus_idle;
	logic [FLAG_W-1:0] err_flags;
	logic [7:0]        exp_fl = '0, msk = '0, e, m;
	logic              esum = 1'b0;
	int                n_errors = 0, num_checks = 0, seed = 89892;
	int                n_adv = 0, exp_adv = 0, n_aclr = 0, exp_aclr = 0;

	always #12.5 aclk = ~aclk;

	usb_engine_model u_eng (.aclk(aclk), .events(events), .bus_idle(bus_idle), .err_flags(err_flags));

	usb_event_flag_register #(.IDLE_CYCLES(IDLE_N)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .events(events),
		.bus_idle(bus_idle), .err_flags(err_flags), .fifo_advance(fifo_advance),
		.address_clear(address_clear), .irq(irq)
	);

	always @(posedge aclk) begin
		if (fifo_advance === 1'b1) n_adv++;
		if (address_clear === 1'b1) n_aclr++;
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= 40) begin
			n_errors++;
			end_sim;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		tmo(n);
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rdv = rdata;
		resp = rresp;
		tmo(n);
	endtask

	task automatic rdf;
		rd(OFS_FLAGS);
		`CHK("flags", {24'h0, exp_fl & 8'h7D | {6'h0, esum, 1'b0}}, rdv)
	endtask

	task automatic ev(input logic [4:0] v);
		u_eng.pulse(v);
		exp_fl |= {1'b0, v[4:3], 1'b0, v[2:1], 1'b0, v[0]};
		exp_aclr += v[0];
	endtask

	task automatic clr(input logic [7:0] c);
		wr(OFS_FLAGS, {24'h0, c});
		if (c[3] && exp_fl[3]) exp_adv++;
		exp_fl &= ~(c & 8'h7D);
	endtask

	task automatic irqchk;
		@(negedge aclk);
		`CHK("irq", |((exp_fl & 8'h7D | {6'h0, esum, 1'b0}) & msk), irq)
		@(posedge aclk);
	endtask

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdf();
		rd(OFS_MASK);
		`CHK("mask", 32'h0, rdv)
		for (int i = 0; i < 5; i++) begin
			ev(5'b10000 >> i);
			rdf();
		end
		`CHK("addr clear", exp_aclr, n_aclr)
		clr(8'hFF);
		rdf();
		clr(8'h08);
		for (int i = 0; i < 6; i++) begin
			rv = $random(seed);
			ev(rv[4:0]);
			clr(rv[15:8]);
			rdf();
		end
		`CHK("fifo advance", exp_adv, n_adv)
		u_eng.idle_for(IDLE_N - 1);
		rdf();
		u_eng.idle_for(IDLE_N);
		exp_fl[BIT_IDLE] = 1'b1;
		rdf();
		msk = 8'h04;
		wr(OFS_MASK, 32'h0000_0004);
		rd(OFS_MASK);
		`CHK("mask", 32'h0000_0004, rdv)
		irqchk();
		ev(5'b00010);
		irqchk();
		clr(8'h04);
		irqchk();
		for (int i = 0; i < 4; i++) begin
			rv = $random(seed);
			e = rv[7:0] | 8'h01;
			m = i[0] ? rv[15:8] | 8'h01 : rv[15:8] & 8'hFE;
			wr(OFS_ERR_EN, {24'h0, m});
			rd(OFS_ERR_EN);
			`CHK("err enable", {24'h0, m}, rdv)
			u_eng.set_err(e);
			esum = |(e & m);
			rdf();
			clr(8'h02);
			rdf();
		end
		// mid-run reset with flags pending
		ev(5'b11111);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		exp_fl = '0;
		msk = '0;
		esum = 1'b0;
		rdf();
		rd(OFS_MASK);
		`CHK("mask", 32'h0, rdv)
		irqchk();
		rd(8'h0C);
		`CHK("rresp", RESP_SLVERR, resp)
		`CHK("unmapped data", 32'h0, rdv)
		wr(8'h0C, 32'h0000_00FF);
		`CHK("bresp", RESP_SLVERR, resp)
		`CHK("addr clear", exp_aclr, n_aclr)
		`CHK("fifo advance", exp_adv, n_adv)
		end_sim;
	end
endmodule
